// File: src/mtr_pkg.sv
// Package for the memory type resolver: type codes, attribute table layout and carriers.
// Assumes a single core clock domain and a synchronous active-high reset.
package mtr_pkg;

  // ----------------------------------------------------------------------
  // Memory type encodings
  // ----------------------------------------------------------------------
  localparam logic [7:0] MTR_TYPE_UNCACHEABLE = 8'h00;
  localparam logic [7:0] MTR_TYPE_WRITE_COMBINING = 8'h01;
  localparam logic [7:0] MTR_TYPE_WRITETHROUGH = 8'h04;
  localparam logic [7:0] MTR_TYPE_WRITE_PROTECT = 8'h05;
  localparam logic [7:0] MTR_TYPE_WRITEBACK = 8'h06;
  localparam logic [7:0] MTR_TYPE_WEAK_UNCACHEABLE = 8'h07;

  // ----------------------------------------------------------------------
  // Attribute table layout
  // ----------------------------------------------------------------------
  localparam int MTR_SLOT_COUNT = 8;
  localparam int MTR_SLOT_STRIDE = 8;
  localparam int MTR_SLOT_CODE_BITS = 3;
  localparam logic [63:0] MTR_TABLE_RESET = 64'h0007040600070406;
  localparam logic [7:0] MTR_SLOT_RESERVED_MASK = 8'hF8;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic attr_table_bit;
    logic page_cache_disable_bit;
    logic page_writethrough_bit;
  } mtr_page_bits_t;

  typedef struct packed {
    logic uncached;
    logic combine_ok;
    logic spec_read_ok;
    logic read_alloc;
    logic read_alloc_excl;
    logic write_alloc;
    logic write_thru;
    logic write_hit_inval;
  } mtr_policy_t;

  typedef struct packed {
    logic [7:0] eff_type;
    logic eff_defined;
    logic wc_impl_dep;
    mtr_policy_t policy;
    logic wr_fault;
    logic wr_done;
    logic [63:0] table_rd;
  } mtr_out_t;

endpackage

// File: src/mtr_policy.sv
// Maps one effective memory type onto the caching behaviour the cache and bus logic follow.
// Assumes the type input is one of the supported codes; others map to the uncached set.
`timescale 1ns/1ps
module mtr_policy
(
  input wire logic [7:0] i_type,
  output mtr_pkg::mtr_policy_t o_policy
);

  always_comb
  begin
    o_policy = '0;
    unique case (i_type)
      mtr_pkg::MTR_TYPE_WRITE_COMBINING:
      begin
        o_policy.uncached = 1'b1;
        o_policy.combine_ok = 1'b1;
        o_policy.spec_read_ok = 1'b1;
      end
      mtr_pkg::MTR_TYPE_WRITETHROUGH:
      begin
        o_policy.read_alloc = 1'b1;
        o_policy.write_thru = 1'b1;
      end
      mtr_pkg::MTR_TYPE_WRITE_PROTECT:
      begin
        o_policy.read_alloc = 1'b1;
        o_policy.write_thru = 1'b1;
        o_policy.write_hit_inval = 1'b1;
      end
      mtr_pkg::MTR_TYPE_WRITEBACK:
      begin
        o_policy.read_alloc = 1'b1;
        o_policy.read_alloc_excl = 1'b1;
        o_policy.write_alloc = 1'b1;
      end
      default:
      begin
        // Uncacheable and weak uncacheable: nothing cached, merged or speculated.
        o_policy.uncached = 1'b1;
      end
    endcase
  end

endmodule

// File: src/mtr_resolver.sv
// Memory type resolver: range-type overlap resolution, page-bit combination,
// attribute table register with checked writes, and the per-type caching policy.
// Assumes the translation logic presents page bits and range types with the request,
// and that model-specific register writes arrive as a one-cycle strobe with data.
// The resolved result is registered, so the cache side must expect it one cycle
// after the request it belongs to.
`timescale 1ns/1ps
module mtr_resolver
#(
  parameter int VAR_RANGES = 8
)
(
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic i_global_cache_disable,
  input wire logic i_global_not_writethrough,
  input wire logic i_range_enable,
  input wire logic [7:0] i_default_type,
  input wire logic i_fixed_hit,
  input wire logic [7:0] i_fixed_type,
  input wire logic [VAR_RANGES-1:0] i_var_hit,
  input wire logic [VAR_RANGES*8-1:0] i_var_types,
  input wire logic i_large_page,
  input wire logic i_large_page_mixed,
  input wire mtr_pkg::mtr_page_bits_t i_page,
  input wire logic i_table_wr,
  input wire logic [63:0] i_table_wdata,
  output mtr_pkg::mtr_out_t o_result
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [63:0] table_val;
    mtr_pkg::mtr_out_t out;
  } mtr_state_t;

  mtr_state_t state_r;
  mtr_state_t state_nxt;

  // ----------------------------------------------------------------------
  // Variable-range overlap resolution
  // ----------------------------------------------------------------------
  logic [VAR_RANGES-1:0] var_is_uc;
  logic [VAR_RANGES-1:0] var_is_wt;
  logic [VAR_RANGES-1:0] var_is_wb;
  logic [VAR_RANGES-1:0] var_same;
  logic [7:0] first_type;

  // The first hit's type is the reference for the all-equal test.
  always_comb
  begin
    first_type = i_default_type;
    for (int k = VAR_RANGES - 1; k >= 0; k--)
    begin
      if (i_var_hit[k])
      begin
        first_type = i_var_types[k*8 +: 8];
      end
    end
  end

  // Per-range flags; a range that does not hit never takes part in an overlap test.
  genvar g;
  generate
    for (g = 0; g < VAR_RANGES; g++)
    begin : gen_var
      assign var_is_uc[g] = i_var_hit[g] &&
        (i_var_types[g*8 +: 8] == mtr_pkg::MTR_TYPE_UNCACHEABLE);
      assign var_is_wt[g] = i_var_hit[g] &&
        (i_var_types[g*8 +: 8] == mtr_pkg::MTR_TYPE_WRITETHROUGH);
      assign var_is_wb[g] = i_var_hit[g] &&
        (i_var_types[g*8 +: 8] == mtr_pkg::MTR_TYPE_WRITEBACK);
      assign var_same[g] = !i_var_hit[g] || (i_var_types[g*8 +: 8] == first_type);
    end
  endgenerate

  // Hits that are all writethrough or writeback may resolve to writethrough.
  logic var_only_wt_wb;
  logic [7:0] range_type;
  logic range_defined;

  assign var_only_wt_wb = ((i_var_hit & ~(var_is_wt | var_is_wb)) == '0);

  always_comb
  begin
    range_type = i_default_type;
    range_defined = 1'b1;
    if (!i_range_enable)
    begin
      range_type = mtr_pkg::MTR_TYPE_UNCACHEABLE;
    end
    else if (i_fixed_hit)
    begin
      range_type = i_fixed_type;
    end
    else if (i_var_hit != '0)
    begin
      if (&var_same)
      begin
        range_type = first_type;
      end
      else if (|var_is_uc)
      begin
        range_type = mtr_pkg::MTR_TYPE_UNCACHEABLE;
      end
      else if (var_only_wt_wb)
      begin
        range_type = mtr_pkg::MTR_TYPE_WRITETHROUGH;
      end
      else
      begin
        // Mixed combination: a type is still driven but flagged undefined.
        range_type = mtr_pkg::MTR_TYPE_UNCACHEABLE;
        range_defined = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Range type decode
  // ----------------------------------------------------------------------
  logic range_is_uc;
  logic range_is_wc;
  logic range_is_wp;
  logic range_is_wb;

  assign range_is_uc = (range_type == mtr_pkg::MTR_TYPE_UNCACHEABLE);
  assign range_is_wc = (range_type == mtr_pkg::MTR_TYPE_WRITE_COMBINING);
  assign range_is_wp = (range_type == mtr_pkg::MTR_TYPE_WRITE_PROTECT);
  assign range_is_wb = (range_type == mtr_pkg::MTR_TYPE_WRITEBACK);

  // ----------------------------------------------------------------------
  // Attribute slot selection and page-level combination
  // ----------------------------------------------------------------------
  logic [2:0] slot_idx;
  logic [7:0] slot_type;
  logic [7:0] eff_type;
  logic eff_defined;
  logic wc_impl_dep;

  assign slot_idx = {i_page.attr_table_bit, i_page.page_cache_disable_bit,
    i_page.page_writethrough_bit};
  assign slot_type = state_r.table_val[slot_idx*mtr_pkg::MTR_SLOT_STRIDE +: 8];

  // Combinational here; the cache sees the type through the output register, one cycle after the request.
  always_comb
  begin
    eff_type = range_type;
    eff_defined = range_defined;
    wc_impl_dep = 1'b0;
    if (i_global_cache_disable || i_global_not_writethrough)
    begin
      // Caching globally off: nothing may allocate.
      eff_type = mtr_pkg::MTR_TYPE_UNCACHEABLE;
    end
    else if (range_is_uc)
    begin
      eff_type = mtr_pkg::MTR_TYPE_UNCACHEABLE;
    end
    else
    begin
      unique case (slot_type)
        mtr_pkg::MTR_TYPE_WRITEBACK:
        begin
          eff_type = range_type;
        end
        mtr_pkg::MTR_TYPE_WRITETHROUGH:
        begin
          if (range_is_wb)
          begin
            eff_type = mtr_pkg::MTR_TYPE_WRITETHROUGH;
          end
          else
          begin
            // A writethrough page keeps write-combining and write-protect ranges as they are.
            eff_type = range_type;
          end
        end
        mtr_pkg::MTR_TYPE_WEAK_UNCACHEABLE:
        begin
          if (range_is_wc)
          begin
            eff_type = mtr_pkg::MTR_TYPE_WRITE_COMBINING;
            // Both slots reached with cache-disable set and writethrough clear are flagged.
            wc_impl_dep = i_page.page_cache_disable_bit && !i_page.page_writethrough_bit;
          end
          else
          begin
            eff_type = mtr_pkg::MTR_TYPE_UNCACHEABLE;
          end
        end
        mtr_pkg::MTR_TYPE_WRITE_COMBINING:
        begin
          eff_type = mtr_pkg::MTR_TYPE_WRITE_COMBINING;
        end
        mtr_pkg::MTR_TYPE_WRITE_PROTECT:
        begin
          if (range_is_wp || range_is_wb)
          begin
            eff_type = mtr_pkg::MTR_TYPE_WRITE_PROTECT;
          end
          else
          begin
            eff_type = mtr_pkg::MTR_TYPE_UNCACHEABLE;
            eff_defined = 1'b0;
          end
        end
        default:
        begin
          eff_type = mtr_pkg::MTR_TYPE_UNCACHEABLE;
        end
      endcase
    end
    // The walker reports a mixed large page; the ranges inside it are not visible here.
    if (i_large_page && i_large_page_mixed)
    begin
      eff_defined = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Caching policy of the effective type
  // ----------------------------------------------------------------------
  // The policy follows the effective type, so every override above reaches the cache.
  mtr_pkg::mtr_policy_t policy;

  mtr_policy u_policy
  (
    .i_type(eff_type),
    .o_policy(policy)
  );

  // ----------------------------------------------------------------------
  // Attribute table write check
  // ----------------------------------------------------------------------
  logic [mtr_pkg::MTR_SLOT_COUNT-1:0] slot_bad;

  generate
    for (g = 0; g < mtr_pkg::MTR_SLOT_COUNT; g++)
    begin : gen_slot
      logic [7:0] code;
      logic code_known;
      assign code = i_table_wdata[g*mtr_pkg::MTR_SLOT_STRIDE +: 8];
      assign code_known = (code == mtr_pkg::MTR_TYPE_UNCACHEABLE) ||
        (code == mtr_pkg::MTR_TYPE_WRITE_COMBINING) ||
        (code == mtr_pkg::MTR_TYPE_WRITETHROUGH) ||
        (code == mtr_pkg::MTR_TYPE_WRITE_PROTECT) ||
        (code == mtr_pkg::MTR_TYPE_WRITEBACK) ||
        (code == mtr_pkg::MTR_TYPE_WEAK_UNCACHEABLE);
      assign slot_bad[g] = ((code & mtr_pkg::MTR_SLOT_RESERVED_MASK) != 8'h00) ||
        !code_known;
    end
  endgenerate

  logic wr_bad;

  // One bad slot refuses the whole word, so the table is never partly updated.
  assign wr_bad = |slot_bad;

  // ----------------------------------------------------------------------
  // Next state and register
  // ----------------------------------------------------------------------
  // The outputs are registered copies, so they trail the inputs by one cycle; the
  // combinational view lives inside this module where the request is resolved.
  // No consistency check against other processors exists here.
  always_comb
  begin
    state_nxt = state_r;
    state_nxt.out.wr_fault = 1'b0;
    state_nxt.out.wr_done = 1'b0;
    if (i_table_wr)
    begin
      if (wr_bad)
      begin
        state_nxt.out.wr_fault = 1'b1;
      end
      else
      begin
        state_nxt.table_val = i_table_wdata;
        state_nxt.out.wr_done = 1'b1;
      end
    end
    state_nxt.out.eff_type = eff_type;
    state_nxt.out.eff_defined = eff_defined;
    state_nxt.out.wc_impl_dep = wc_impl_dep;
    state_nxt.out.policy = policy;
    state_nxt.out.table_rd = state_nxt.table_val;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_reset)
    begin
      state_r <= '0;
      state_r.table_val <= mtr_pkg::MTR_TABLE_RESET;
      state_r.out.table_rd <= mtr_pkg::MTR_TABLE_RESET;
      state_r.out.eff_type <= mtr_pkg::MTR_TYPE_UNCACHEABLE;
      state_r.out.policy.uncached <= 1'b1;
      // Flags and pulses start low so no write answer shows before the first write.
      state_r.out.eff_defined <= 1'b0;
      state_r.out.wc_impl_dep <= 1'b0;
      state_r.out.wr_fault <= 1'b0;
      state_r.out.wr_done <= 1'b0;
    end
    else if (i_clk_en)
    begin
      state_r <= state_nxt;
    end
  end

  assign o_result = state_r.out;

endmodule

// File: verif/mtr_resolver_asserts.sv
// Port-level checker for the memory type resolver.
// Assumes one core clock and the synchronous active-high reset of the resolver.
`timescale 1ns/1ps
module mtr_resolver_asserts
(
  input wire logic i_core_clk,
  input wire logic i_reset,
  input wire logic i_clk_en,
  input wire logic i_global_cache_disable,
  input wire logic i_global_not_writethrough,
  input wire logic i_large_page,
  input wire logic i_large_page_mixed,
  input wire mtr_pkg::mtr_page_bits_t i_page,
  input wire logic i_table_wr,
  input wire logic [63:0] i_table_wdata,
  input wire mtr_pkg::mtr_out_t o_result
);
  logic bad;
  logic [7:0] slot;
  logic glob;

  assign slot = o_result.table_rd[{i_page, 3'h0} +: 8];
  assign glob = i_global_cache_disable | i_global_not_writethrough;

  always_comb
  begin
    bad = 1'b0;
    for (int k = 0; k < 8; k++)
    begin
      bad = bad | (|i_table_wdata[k*8+3 +: 5]) | (i_table_wdata[k*8+1 +: 2] == 2'h1);
    end
  end

  // ----
  // Properties
  // ----
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  a_write_answer: assert property (i_clk_en && i_table_wr |=>
    o_result.wr_done != o_result.wr_fault)
    else $error("table write gave no single answer");
  a_bad_write: assert property (i_clk_en && i_table_wr && bad |=>
    o_result.wr_fault && $stable(o_result.table_rd))
    else $error("bad table write was not refused");
  a_good_write: assert property (i_clk_en && i_table_wr && !bad |=>
    o_result.table_rd == $past(i_table_wdata))
    else $error("good table write not stored");
  a_reset_table: assert property (disable iff (1'b0) i_reset |=>
    o_result.table_rd == mtr_pkg::MTR_TABLE_RESET)
    else $error("table not at defaults after reset");
  a_global_uc: assert property (i_clk_en && glob |=>
    o_result.eff_type == mtr_pkg::MTR_TYPE_UNCACHEABLE)
    else $error("global cache controls not uncacheable");
  a_uc_slot: assert property (i_clk_en && !glob && slot == 8'h00 |=>
    o_result.eff_type == 8'h00)
    else $error("uncacheable slot did not give uncacheable");
  a_large_undef: assert property (i_clk_en && !glob &&
    i_large_page && i_large_page_mixed |=> !o_result.eff_defined)
    else $error("mixed large page reported defined");
  a_uc_policy: assert property (o_result.eff_type == 8'h00 |->
    o_result.policy.uncached && !o_result.policy.combine_ok &&
    !o_result.policy.spec_read_ok && !o_result.policy.read_alloc)
    else $error("uncacheable policy wrong");
  a_wc_policy: assert property (o_result.eff_type == 8'h01 |->
    o_result.policy.combine_ok && o_result.policy.uncached && !o_result.policy.read_alloc)
    else $error("write-combining policy wrong");
  a_wb_policy: assert property (o_result.eff_type == 8'h06 |->
    o_result.policy.write_alloc && !o_result.policy.uncached)
    else $error("writeback policy wrong");
  a_hold_frozen: assert property (!i_clk_en |=> $stable(o_result))
    else $error("outputs moved with clock enable low");
endmodule

bind mtr_resolver mtr_resolver_asserts chk_u (.i_core_clk, .i_reset, .i_clk_en,
  .i_global_cache_disable, .i_global_not_writethrough, .i_large_page, .i_large_page_mixed,
  .i_page, .i_table_wr, .i_table_wdata, .o_result);

// File: verif/mtr_xlat_model.sv
// Translation-side model: page index bits and variable-range hits with types.
// Missed ranges show inverted type fields, as a walker leaves stale data there.
`timescale 1ns/1ps
module mtr_xlat_model #(parameter int N = 4)
(
  input wire logic [2:0] i_idx,
  input wire logic [N-1:0] i_hit,
  input wire logic [N*8-1:0] i_types,
  output mtr_pkg::mtr_page_bits_t o_page,
  output logic [N-1:0] o_var_hit,
  output logic [N*8-1:0] o_var_types
);
  assign o_page = mtr_pkg::mtr_page_bits_t'(i_idx);
  assign o_var_hit = i_hit;
  always_comb
  begin
    for (int k = 0; k < N; k++)
    begin
      o_var_types[k*8 +: 8] = i_hit[k] ? i_types[k*8 +: 8] : ~i_types[k*8 +: 8];
    end
  end
endmodule

// File: verif/mtr_resolver_tb.sv
// Self-checking bench for the memory type resolver against a reference model.
// Assumes the package, resolver, checker and translation model are compiled first.
`timescale 1ns/1ps
module mtr_resolver_tb;
  logic clk = 1'b0;
  logic rst, en, gcd, gnw, ren, fhit, lp, lpm, wr;
  logic [7:0] dflt, ftype;
  logic [3:0] hit, vh;
  logic [31:0] types, vt;
  logic [2:0] idx;
  logic [63:0] wd, tbl;
  mtr_pkg::mtr_page_bits_t page;
  mtr_pkg::mtr_out_t res;
  int err_count = 0;
  int checked = 0;
  int et;
  bit ct, cd, cw, edf, ewc, ewd, ewf;
  int pool[6] = '{0, 1, 4, 5, 6, 7};
  logic [63:0] wlist[5] = '{64'h0706050401000406, 64'h0000000008000000,
    64'h0000020000000000, 64'h0300000000000000, 64'h0007040600070406};

  always #25 clk = ~clk;

  mtr_xlat_model #(.N(4)) xm_u (.i_idx(idx), .i_hit(hit), .i_types(types), .o_page(page),
    .o_var_hit(vh), .o_var_types(vt));
  mtr_resolver #(.VAR_RANGES(4)) dut_u (.i_core_clk(clk), .i_reset(rst), .i_clk_en(en),
    .i_global_cache_disable(gcd), .i_global_not_writethrough(gnw), .i_range_enable(ren),
    .i_default_type(dflt), .i_fixed_hit(fhit), .i_fixed_type(ftype), .i_var_hit(vh),
    .i_var_types(vt), .i_large_page(lp), .i_large_page_mixed(lpm), .i_page(page),
    .i_table_wr(wr), .i_table_wdata(wd), .o_result(res));

  // ----
  // Reference model
  // ----
  function automatic bit badw(logic [63:0] w);
    bit b = 0;
    for (int k = 0; k < 8; k++)
      b |= (w[k*8 +: 8] > 8'h07) || (w[k*8 +: 8] inside {8'h02, 8'h03});
    return b;
  endfunction

  // Returns -1 where overlapping range types give no defined result.
  function automatic int rtype();
    int t;
    int first = -1;
    bit same = 1;
    bit uc = 0;
    bit oth = 0;
    if (!ren) return 0;
    if (fhit) return ftype;
    for (int k = 0; k < 4; k++)
      if (hit[k])
      begin
        t = types[k*8 +: 8];
        if (first < 0) first = t;
        same &= (t == first);
        uc |= (t == 0);
        oth |= (t != 4 && t != 6);
      end
    if (first < 0) return dflt;
    if (same) return first;
    if (uc) return 0;
    return oth ? -1 : 4;
  endfunction

  function automatic int cmb(int s, int r);
    if (r == 0) return 0;
    case (s)
      6: return r;
      4: return (r == 6) ? 4 : r;
      7: return (r == 1) ? 1 : 0;
      1: return 1;
      5: return (r >= 5) ? 5 : -1;
      default: return 0;
    endcase
  endfunction

  function automatic logic [7:0] pol(int t);
    case (t)
      1: return 8'hE0;
      4: return 8'h12;
      5: return 8'h13;
      6: return 8'h1C;
      default: return 8'h80;
    endcase
  endfunction

  task automatic predict();
    int s, r, e;
    if (!en) return;
    s = tbl[idx*8 +: 8];
    r = rtype();
    e = (r < 0) ? -1 : cmb(s, r);
    ewd = wr && !badw(wd);
    ewf = wr && badw(wd);
    ct = 1;
    et = 0;
    cd = !(gcd || gnw);
    edf = (e >= 0) && !(lp && lpm);
    cw = cd && edf && idx[1:0] == 2'h2 && s == 7;
    ewc = (r == 1);
    if (cd) ct = edf;
    if (cd) et = e;
    if (ewd) tbl = wd;
  endtask

  // ----
  // Checks and drivers
  // ----
  task automatic chk_val(string n, logic [63:0] e, logic [63:0] g);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, g);
    end
  endtask

  // Speculative reads on cacheable types are left to the design.
  task automatic chk_pol(logic [7:0] e, mtr_pkg::mtr_policy_t g);
    logic [7:0] m;
    m = e[7] ? 8'hFF : 8'hDF;
    chk_val("policy", e & m, g & m);
  endtask

  task automatic check();
    chk_val("wr_done", ewd, res.wr_done);
    chk_val("wr_fault", ewf, res.wr_fault);
    chk_val("table_rd", tbl, res.table_rd);
    if (ct) chk_val("eff_type", et, res.eff_type);
    if (ct) chk_pol(pol(et), res.policy);
    if (cd) chk_val("eff_defined", edf, res.eff_defined);
    if (cw) chk_val("wc_impl_dep", ewc, res.wc_impl_dep);
  endtask

  task automatic step();
    predict();
    @(negedge clk);
    check();
  endtask

  task automatic do_reset(int n);
    rst = 1'b1;
    en = 1'b1;
    wr = 1'b0;
    repeat (n) @(negedge clk);
    rst = 1'b0;
    tbl = mtr_pkg::MTR_TABLE_RESET;
    {ct, cd, edf, cw, ewc, ewd, ewf} = 7'h58;
    et = 0;
    check();
  endtask

  task automatic rnd();
    en = ($urandom % 8) != 0;
    gcd = ($urandom % 12) == 0;
    gnw = ($urandom % 12) == 0;
    ren = ($urandom % 12) != 0;
    fhit = ($urandom % 4) == 0;
    dflt = 8'(pool[$urandom % 5]);
    ftype = 8'(pool[$urandom % 5]);
    hit = 4'($urandom);
    lp = 1'($urandom);
    lpm = ($urandom % 4) == 0;
    idx = 3'($urandom);
    wr = ($urandom % 6) == 0;
    for (int k = 0; k < 8; k++)
    begin
      if (k < 4) types[k*8 +: 8] = 8'(pool[$urandom % 5]);
      wd[k*8 +: 8] = 8'(pool[$urandom % 6]);
    end
    if (($urandom % 3) == 0) wd[($urandom % 8)*8 +: 8] = 8'(2 + $urandom % 8);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    {gcd, gnw, ren, fhit, lp, lpm} = 6'h00;
    {dflt, ftype, hit, types, idx, wd} = '0;
    void'($urandom(47));
    do_reset(6);
    $display("test reset done");
    ren = 1'b1;
    for (int i = 0; i < 40; i++)
    begin
      idx = 3'(i / 5);
      dflt = 8'(pool[i % 5]);
      step();
    end
    $display("test page bits done");
    wr = 1'b1;
    foreach (wlist[i])
    begin
      wd = wlist[i];
      idx = 3'(i);
      step();
    end
    wr = 1'b0;
    $display("test table writes done");
    repeat (400)
    begin
      rnd();
      step();
    end
    $display("test random done");
    do_reset(1);
    $display("test second reset done");
    end_sim();
  end

  initial
  begin
    #100000;
    err_count++;
    $display("[FAIL] watchdog expected done seen timeout");
    end_sim();
  end
endmodule
